//--- inc/dout_sel_defs.vh
// Operation
// RQ1: report board status; failed diagnostics blocks armature
// RQ2: two outputs, each own source and polarity
// RQ3: output 1 normally open follows source directly
// RQ4: output 1 normally closed inverts the source
// RQ5: contacts forced open until diagnostics complete
// RQ6: output 1 from level detector 1 or 2
// RQ7: current-limit source drives output
// RQ8: start-permissive source drives output
// RQ9: link health flag source drives output
// RQ10: bit 0 of host word 1-3 drives output
// RQ11: host word sources need network board
// RQ12: host words update only network control active
// RQ13: output 2 normally open follows source directly
// RQ14: output 2 normally closed inverts the source
// RQ15: output 2 same eight sources, default detector 2
// RQ16: rejected host word choice keeps old source
`ifndef DOUT_SEL_DEFS_VH
`define DOUT_SEL_DEFS_VH
`define REG_CTRL 4'h0
`define REG_OUT1_SRC 4'h1
`define REG_OUT2_SRC 4'h2
`define REG_STATUS 4'h3
`define REG_WORD_A 4'h4
`define REG_WORD_B 4'h5
`define REG_WORD_C 4'h6
`define SRC_LVL1 3'h0
`define SRC_LVL2 3'h1
`define SRC_CLIM 3'h2
`define SRC_READY 3'h3
`define SRC_LINK 3'h4
`define SRC_WORD_A 3'h5
`define SRC_WORD_B 3'h6
`define SRC_WORD_C 3'h7
`define BRD_NONE 2'h0
`define BRD_OK 2'h1
`define BRD_FAIL 2'h2
`define CTRL_POL1_BIT 0
`define CTRL_POL2_BIT 1
`define POL_NO 1'b0
`define WORD_W 16
`define SRC_W 3
`define HOST_BIT 0
`define WSEL_A 0
`define WSEL_B 1
`define WSEL_C 2
`define SIG_N 9
`define SIG_DIAG 8
`define SIG_NETBRD 7
`define SIG_LVL1 6
`define SIG_LVL2 5
`define SIG_CLIM 4
`define SIG_READY 3
`define SIG_LINK 2
`define SIG_NETCTL 1
`define SIG_NETACT 0
`define ST_BRD_HI 1
`define ST_BRD_LO 0
`define ST_NETBRD_BIT 2
`define ST_DIAG_BIT 3
`define ST_OUT1_BIT 4
`define ST_OUT2_BIT 5
`endif

//--- verilog/dout_sel.v
`timescale 1ns/1ps
`include "dout_sel_defs.vh"
module dout_sel (
    input wire clk,
    input wire sys_rst,
    input wire [3:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    output reg [31:0] avs_readdata,
    output wire avs_waitrequest,
    input wire [1:0] board_status,
    input wire diag_done,
    input wire netboard_present,
    input wire lvl_det1,
    input wire lvl_det2,
    input wire in_current_limit,
    input wire drive_ready,
    input wire link_health_flag,
    input wire net_control_sel,
    input wire net_active,
    input wire [15:0] host_word_a_in,
    input wire [15:0] host_word_b_in,
    input wire [15:0] host_word_c_in,
    input wire host_word_strobe,
    output reg out1_closed_r,
    output reg out2_closed_r,
    output reg armature_inhibit_r
);

// one wait cycle per access: waitrequest high in the first cycle
reg ack_r;
wire ack_nxt;
wire req;
wire do_wr;
wire do_rd;

// configuration state
reg out1_contact_polarity;
reg out2_contact_polarity;
reg [`SRC_W-1:0] out1_source_choice;
reg [`SRC_W-1:0] out2_source_choice;
reg [`WORD_W-1:0] host_word_a;
reg [`WORD_W-1:0] host_word_b;
reg [`WORD_W-1:0] host_word_c;

// pin synchroniser stages
reg [`SIG_N-1:0] s1_r;
reg [`SIG_N-1:0] s2_r;
reg [`SIG_N-1:0] s3_r;
reg [`SIG_N-1:0] sig_r;
wire [`SIG_N-1:0] sig_raw;
reg [1:0] st1_r;
reg [1:0] st2_r;
reg [1:0] st3_r;
reg [1:0] diag_failure_state_r;
integer i;

// synchronised pin levels
wire diag_ok;
wire netboard_ok;
wire net_ctl_ok;
wire net_act_ok;
wire word_load;

// write decode
wire [`SRC_W-1:0] wr_src;
wire src_ok;
wire wr_ctrl;
wire wr_out1;
wire wr_out2;

// read path and contact drive
reg [31:0] rd_mux;
reg [31:0] stat_word;
wire [2:0] wbits;
wire src1;
wire src2;
wire out1_nxt;
wire out2_nxt;
wire inhibit_nxt;

function is_word_src;
    input [`SRC_W-1:0] s;
    begin
        is_word_src = (s == `SRC_WORD_A) | (s == `SRC_WORD_B) |
            (s == `SRC_WORD_C);
    end
endfunction

function pick_src;
    input [`SRC_W-1:0] s;
    input [`SIG_N-1:0] v;
    input [2:0] w;
    begin
        case (s)
            `SRC_LVL1: pick_src = v[`SIG_LVL1]; // RQ6
            `SRC_LVL2: pick_src = v[`SIG_LVL2]; // RQ6
            `SRC_CLIM: pick_src = v[`SIG_CLIM]; // RQ7
            `SRC_READY: pick_src = v[`SIG_READY]; // RQ8
            `SRC_LINK: pick_src = v[`SIG_LINK]; // RQ9
            `SRC_WORD_A: pick_src = w[`WSEL_A]; // RQ10
            `SRC_WORD_B: pick_src = w[`WSEL_B]; // RQ10
            `SRC_WORD_C: pick_src = w[`WSEL_C]; // RQ10
            default: pick_src = 1'b0;
        endcase
    end
endfunction

// contact closed when enabled and source differs from polarity
function contact_level;
    input en;
    input src;
    input pol;
    begin
        contact_level = en & (src ^ pol);
    end
endfunction

assign req = avs_read | avs_write;
assign ack_nxt = req & ~ack_r;
assign avs_waitrequest = req & ~ack_r;
assign do_wr = avs_write & ~avs_waitrequest;
assign do_rd = avs_read & ~ack_r;
assign sig_raw = {diag_done, netboard_present, lvl_det1, lvl_det2,
    in_current_limit, drive_ready, link_health_flag, net_control_sel,
    net_active};

assign diag_ok = sig_r[`SIG_DIAG];
assign netboard_ok = sig_r[`SIG_NETBRD];
assign net_ctl_ok = sig_r[`SIG_NETCTL];
assign net_act_ok = sig_r[`SIG_NETACT];
assign word_load = host_word_strobe & net_ctl_ok & net_act_ok; // RQ12

assign wr_src = avs_writedata[`SRC_W-1:0];
assign src_ok = !is_word_src(wr_src) | netboard_ok; // RQ11
assign wr_ctrl = do_wr & (avs_address == `REG_CTRL);
assign wr_out1 = do_wr & (avs_address == `REG_OUT1_SRC);
assign wr_out2 = do_wr & (avs_address == `REG_OUT2_SRC);

// bus acknowledge
always @(posedge clk or posedge sys_rst)
begin
    if (sys_rst)
        ack_r <= 1'b0;
    else
        ack_r <= ack_nxt;
end

// pin synchronisers: change taken when stages 2 and 3 agree
always @(posedge clk or posedge sys_rst)
begin
    if (sys_rst)
    begin
        s1_r <= {`SIG_N{1'b0}};
        s2_r <= {`SIG_N{1'b0}};
        s3_r <= {`SIG_N{1'b0}};
        sig_r <= {`SIG_N{1'b0}};
    end
    else
    begin
        s1_r <= sig_raw;
        s2_r <= s1_r;
        s3_r <= s2_r;
        for (i = 0; i < `SIG_N; i = i + 1)
            if (s2_r[i] == s3_r[i])
                sig_r[i] <= s3_r[i];
    end
end

// board status synchroniser
always @(posedge clk or posedge sys_rst)
begin
    if (sys_rst)
    begin
        st1_r <= `BRD_NONE;
        st2_r <= `BRD_NONE;
        st3_r <= `BRD_NONE;
    end
    else
    begin
        st1_r <= board_status;
        st2_r <= st1_r;
        st3_r <= st2_r;
    end
end

// board status taken once stages 2 and 3 agree
always @(posedge clk or posedge sys_rst)
begin
    if (sys_rst)
        diag_failure_state_r <= `BRD_NONE;
    else if (st2_r == st3_r)
        diag_failure_state_r <= st3_r; // RQ1
end

// host word a: strobe is same-clock logic
always @(posedge clk or posedge sys_rst)
begin
    if (sys_rst)
        host_word_a <= {`WORD_W{1'b0}};
    else if (word_load)
        host_word_a <= host_word_a_in; // RQ12
end

// host word b
always @(posedge clk or posedge sys_rst)
begin
    if (sys_rst)
        host_word_b <= {`WORD_W{1'b0}};
    else if (word_load)
        host_word_b <= host_word_b_in; // RQ12
end

// host word c
always @(posedge clk or posedge sys_rst)
begin
    if (sys_rst)
        host_word_c <= {`WORD_W{1'b0}};
    else if (word_load)
        host_word_c <= host_word_c_in; // RQ12
end

// output 1 contact polarity
always @(posedge clk or posedge sys_rst)
begin
    if (sys_rst)
        out1_contact_polarity <= `POL_NO;
    else if (wr_ctrl)
        out1_contact_polarity <= avs_writedata[`CTRL_POL1_BIT]; // RQ2
end

// output 2 contact polarity
always @(posedge clk or posedge sys_rst)
begin
    if (sys_rst)
        out2_contact_polarity <= `POL_NO;
    else if (wr_ctrl)
        out2_contact_polarity <= avs_writedata[`CTRL_POL2_BIT]; // RQ2
end

// output 1 source; word sources refused without network board
always @(posedge clk or posedge sys_rst)
begin
    if (sys_rst)
        out1_source_choice <= `SRC_LVL1; // RQ6
    else if (wr_out1 & src_ok)
        out1_source_choice <= wr_src; // RQ16
end

// output 2 source
always @(posedge clk or posedge sys_rst)
begin
    if (sys_rst)
        out2_source_choice <= `SRC_LVL2; // RQ15
    else if (wr_out2 & src_ok)
        out2_source_choice <= wr_src; // RQ16
end

// status word
always @*
begin
    stat_word = 32'h00000000;
    stat_word[`ST_BRD_HI:`ST_BRD_LO] = diag_failure_state_r; // RQ1
    stat_word[`ST_NETBRD_BIT] = netboard_ok;
    stat_word[`ST_DIAG_BIT] = diag_ok;
    stat_word[`ST_OUT1_BIT] = out1_closed_r;
    stat_word[`ST_OUT2_BIT] = out2_closed_r;
end

// read multiplexer
always @*
begin
    rd_mux = 32'h00000000;
    case (avs_address)
        `REG_CTRL:
        begin
            rd_mux[`CTRL_POL1_BIT] = out1_contact_polarity;
            rd_mux[`CTRL_POL2_BIT] = out2_contact_polarity;
        end
        `REG_OUT1_SRC:
            rd_mux[`SRC_W-1:0] = out1_source_choice;
        `REG_OUT2_SRC:
            rd_mux[`SRC_W-1:0] = out2_source_choice;
        `REG_STATUS:
            rd_mux = stat_word;
        `REG_WORD_A:
            rd_mux[`WORD_W-1:0] = host_word_a;
        `REG_WORD_B:
            rd_mux[`WORD_W-1:0] = host_word_b;
        `REG_WORD_C:
            rd_mux[`WORD_W-1:0] = host_word_c;
        default:
            rd_mux = 32'h00000000;
    endcase
end

// read data captured in the wait cycle, held until the next read
always @(posedge clk or posedge sys_rst)
begin
    if (sys_rst)
        avs_readdata <= 32'h00000000;
    else if (do_rd)
        avs_readdata <= rd_mux;
end

// contact drive: open until diagnostics complete
assign wbits = {host_word_c[`HOST_BIT], host_word_b[`HOST_BIT],
    host_word_a[`HOST_BIT]};
assign src1 = pick_src(out1_source_choice, sig_r, wbits);
assign src2 = pick_src(out2_source_choice, sig_r, wbits); // RQ15
assign out1_nxt = contact_level(diag_ok, src1,
    out1_contact_polarity); // RQ3 RQ4 RQ5
assign out2_nxt = contact_level(diag_ok, src2,
    out2_contact_polarity); // RQ13 RQ14 RQ5
assign inhibit_nxt = (diag_failure_state_r == `BRD_FAIL); // RQ1

// output 1 contact
always @(posedge clk or posedge sys_rst)
begin
    if (sys_rst)
        out1_closed_r <= 1'b0; // RQ5
    else
        out1_closed_r <= out1_nxt; // RQ3 RQ4
end

// output 2 contact
always @(posedge clk or posedge sys_rst)
begin
    if (sys_rst)
        out2_closed_r <= 1'b0; // RQ5
    else
        out2_closed_r <= out2_nxt; // RQ13 RQ14
end

// armature inhibit on failed board diagnostics
always @(posedge clk or posedge sys_rst)
begin
    if (sys_rst)
        armature_inhibit_r <= 1'b0;
    else
        armature_inhibit_r <= inhibit_nxt; // RQ1
end

endmodule // dout_sel

//--- bench/lamp_model.sv
`timescale 1ns/1ps
module lamp_model (
    input wire clk,
    input wire out1_closed_r,
    input wire out2_closed_r,
    output logic [1:0] lamp_on
);
    // lamp lights one edge after its contact closes
    always @(posedge clk)
        lamp_on <= {out2_closed_r, out1_closed_r};
endmodule // lamp_model

//--- bench/dout_sel_checker.sv
`timescale 1ns/1ps
`include "dout_sel_defs.vh"
module dout_sel_checker (
    input wire clk,
    input wire sys_rst,
    input wire avs_read,
    input wire avs_write,
    input wire avs_waitrequest,
    input wire [31:0] avs_readdata,
    input wire [1:0] board_status,
    input wire diag_done,
    input wire lvl_det1,
    input wire lvl_det2,
    input wire in_current_limit,
    input wire drive_ready,
    input wire link_health_flag,
    input wire host_word_strobe,
    input wire out1_closed_r,
    input wire out2_closed_r,
    input wire armature_inhibit_r
);
    wire req = avs_read | avs_write;
    wire [8:0] cause = {sys_rst, avs_write, lvl_det1, lvl_det2, drive_ready,
        in_current_limit, link_health_flag, diag_done, host_word_strobe};
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    open_until_diag_a: assert property (!diag_done [*8] |->
        !out1_closed_r && !out2_closed_r) else $error("contact closed");
    first_wait_a: assert property ($rose(req) |-> avs_waitrequest)
        else $error("no wait cycle");
    one_wait_a: assert property (req && avs_waitrequest |=>
        !avs_waitrequest) else $error("wait too long");
    idle_wait_a: assert property (!req |-> !avs_waitrequest)
        else $error("wait while idle");
    rdata_hold_a: assert property ($changed(avs_readdata) |->
        $past(avs_read && avs_waitrequest)) else $error("readdata moved");
    inhibit_fail_a: assert property ($stable({sys_rst, board_status}) [*8]
        |-> armature_inhibit_r == (board_status == `BRD_FAIL))
        else $error("inhibit wrong");
    out1_steady_a: assert property ($stable(cause) [*8] |=>
        $stable(out1_closed_r)) else $error("out1 moved");
    out2_steady_a: assert property ($stable(cause) [*8] |=>
        $stable(out2_closed_r)) else $error("out2 moved");
    cover property (out1_closed_r && out2_closed_r);
    cover property (armature_inhibit_r);
    cover property (avs_read && !avs_waitrequest);
endmodule // dout_sel_checker
bind dout_sel dout_sel_checker chk (.*);

//--- bench/test_dout_sel.sv
`timescale 1ns/1ps
`include "dout_sel_defs.vh"
module test_dout_sel;
    logic clk = 0, sys_rst = 1, avs_read = 0, avs_write = 0, diag_done = 0;
    logic netboard_present = 0, net_control_sel = 0, net_active = 0;
    logic host_word_strobe = 0, p1 = 0, p2 = 0;
    logic [3:0] avs_address = 0;
    logic [31:0] avs_writedata = 0, avs_readdata, q;
    logic [1:0] board_status = 0, lamp_on;
    logic [15:0] host_word_a_in = 0, host_word_b_in = 0, host_word_c_in = 0;
    logic [15:0] ha = 0, hb = 0, hc = 0;
    logic [4:0] pins = 0;
    logic [2:0] s1 = 0, s2 = 1;
    logic avs_waitrequest, out1_closed_r, out2_closed_r, armature_inhibit_r;
    wire lvl_det1, lvl_det2, in_current_limit, drive_ready, link_health_flag;
    int n_mismatch = 0, n_compared = 0, cyc = 0;
    assign {link_health_flag, drive_ready, in_current_limit, lvl_det2,
        lvl_det1} = pins;
    dout_sel dut (.*);
    lamp_model lamps (.*);
    initial forever #20 clk = ~clk;
    function logic srcv(input logic [2:0] s);
        logic [7:0] v;
        v = {hc[0], hb[0], ha[0], pins};
        return v[s];
    endfunction
    task automatic give_verdict;
        if (n_mismatch == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, g);
        n_compared++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic bus(input logic w, input logic [3:0] a, input int d);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 0;
        avs_read <= 0;
    endtask
    task automatic outs(input logic en);
        logic a, b;
        repeat (8) @(posedge clk);
        a = en & (srcv(s1) ^ p1);
        b = en & (srcv(s2) ^ p2);
        chk("contacts", {b, a, b, a}, {lamp_on, out2_closed_r, out1_closed_r});
    endtask
    task automatic load(input logic [47:0] w);
        {host_word_a_in, host_word_b_in, host_word_c_in} <= w;
        repeat (8) @(posedge clk);
        host_word_strobe <= 1;
        @(posedge clk);
        host_word_strobe <= 0;
    endtask
    always @(posedge clk)
        if (++cyc == 5000)
        begin
            n_mismatch++;
            give_verdict;
        end
    initial
    begin
        void'($urandom(32'h5842));
        repeat (5) @(posedge clk);
        sys_rst <= 0;
        for (int i = 0; i < 4; i++)
        begin
            bus(0, 4'(i == 3 ? 15 : i), 0);
            chk("reset value", i == 2, q);
        end
        pins <= 5'h1f;
        outs(0);
        diag_done <= 1;
        outs(1);
        for (int i = 0; i < 20; i++)
        begin
            s1 = 3'(i % 5);
            s2 = 3'(4 - i % 5);
            p1 = 1'(i / 5 % 2);
            p2 = 1'(i / 10);
            bus(1, `REG_CTRL, {p2, p1});
            bus(1, `REG_OUT1_SRC, s1);
            bus(1, `REG_OUT2_SRC, s2);
            pins <= 5'($urandom);
            outs(1);
        end
        bus(1, `REG_OUT1_SRC, `SRC_WORD_A);
        bus(0, `REG_OUT1_SRC, 0);
        chk("refused source", s1, q);
        netboard_present <= 1;
        net_control_sel <= 1;
        net_active <= 1;
        load(48'({$urandom, $urandom}));
        {ha, hb, hc} = {host_word_a_in, host_word_b_in, host_word_c_in};
        net_active <= 0;
        load(~{ha, hb, hc});
        for (int k = 5; k < 8; k++)
        begin
            s1 = 3'(k);
            s2 = 3'(12 - k);
            bus(1, `REG_OUT1_SRC, s1);
            bus(1, `REG_OUT2_SRC, s2);
            outs(1);
        end
        for (int b = 0; b < 3; b++)
        begin
            board_status <= 2'(b);
            repeat (8) @(posedge clk);
            bus(0, `REG_STATUS, 0);
            chk("board", {b == 2, srcv(s2) ^ p2, srcv(s1) ^ p1, 2'h3, 2'(b)},
                {armature_inhibit_r, q[5:0]});
        end
        give_verdict;
    end
endmodule // test_dout_sel
